//--- design/intc_consts.svh
// constants for the interrupt priority and mode logic
`ifndef INTC_CONSTS_SVH
`define INTC_CONSTS_SVH

// command word selection bits, port select low
`define SEL_INIT_ONE_BIT 4
`define SEL_STATUS_BIT 3

// init word one fields
`define INIT1_TRIGGER_BIT 3
`define INIT1_SINGLE_BIT 1
`define INIT1_NEED_FOUR_BIT 0

// init word two: vector base occupies the top bits
`define VECTOR_BASE_MSB 7
`define VECTOR_BASE_LSB 3

// reset and post-initialization values
`define MASK_RESET 8'h00
`define IN_SERVICE_RESET 8'h00
`define PENDING_RESET 8'h00
`define BOTTOM_RESET 3'h7
`define DEFAULT_LEVEL 3'h7
`define VECTOR_BASE_RESET 5'h00
`define INIT_FOUR_RESET 8'h00

`endif

//--- design/intc_pkg.sv
// types shared by the interrupt priority and mode logic
package intc_pkg;

  typedef struct packed {
    logic rotate;
    logic level_sel;
    logic end_of_service_cmd;
    logic [1:0] select;
    logic [2:0] level_select_field;
  } priority_command_word_s;

  typedef struct packed {
    logic unused;
    logic selective_mask_write_enable;
    logic selective_mask_mode;
    logic [1:0] select;
    logic poll;
    logic status_read_request;
    logic status_select;
  } status_command_word_s;

  typedef struct packed {
    logic [2:0] unused;
    logic cascade_nested_mode;
    logic buffered;
    logic master;
    logic auto_service_end_mode;
    logic cpu_mode;
  } init_word_four_s;

  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic port_select_line;
    logic ack_n;
    logic [7:0] data;
  } cpu_bus_s;

  typedef enum logic [3:0] {
    INIT_IDLE = 4'b0001,
    INIT_VECTOR = 4'b0010,
    INIT_CASCADE = 4'b0100,
    INIT_FOUR = 4'b1000
  } init_state_e;

endpackage

//--- design/priority_resolver.sv
// rotating priority resolver for requests, in-service blocking and end of service
`timescale 1ns/1ps
`default_nettype none

module priority_resolver
(
  input wire logic [7:0] requests,
  input wire logic [7:0] blocking,
  input wire logic [7:0] eos_candidates,
  input wire logic [2:0] bottom,
  input wire logic nested,
  output logic req_valid,
  output logic [2:0] req_level,
  output logic eos_valid,
  output logic [2:0] eos_level,
  output logic int_ok
);

  // search starts just above the bottom level and wraps round
  function automatic logic [3:0] top_of(input logic [7:0] v, input logic [2:0] b);
    logic [3:0] r;
    logic [2:0] l;
    r = 4'h0;
    for (int k = 7; k >= 0; k--)
    begin
      l = b + 3'h1 + 3'(k);
      if (v[l])
        r = {1'b1, l};
    end
    return r;
  endfunction

  // rank 0 is highest priority
  function automatic logic [2:0] rank_of(input logic [2:0] l, input logic [2:0] b);
    return l - b - 3'h1;
  endfunction

  logic [3:0] req_top;
  logic [3:0] blk_top;
  logic [3:0] eos_top;

  assign req_top = top_of(requests, bottom);
  assign blk_top = top_of(blocking, bottom);
  assign eos_top = top_of(eos_candidates, bottom);
  assign req_valid = req_top[3];
  assign req_level = req_top[2:0];
  assign eos_valid = eos_top[3]; // RULE23
  assign eos_level = eos_top[2:0];

  always_comb
  begin
    if (!blk_top[3])
      int_ok = 1'b1;
    else if (nested)
      int_ok = rank_of(req_top[2:0], bottom) <= rank_of(blk_top[2:0], bottom); // RULE20
    else
      int_ok = rank_of(req_top[2:0], bottom) < rank_of(blk_top[2:0], bottom);
  end

endmodule

`default_nettype wire

//--- design/interrupt_priority_modes.sv
// eight-input interrupt controller: priority, masking, poll and status reads
//
// Contract
// RULE1 - automatic rotation puts serviced input lowest
// RULE2 - rotate with non-specific end of service
// RULE3 - rotate-in-auto-end mode set and cleared
// RULE4 - set priority makes named level bottom
// RULE5 - rotate on specific end clears and rotates
// RULE6 - each mask bit inhibits its own input
// RULE7 - selective mask ignores in-service blocking
// RULE8 - status word enters or leaves selective mask
// RULE9 - read after poll acts as acknowledge
// RULE10 - request state frozen from poll to read
// RULE11 - poll word: pending flag and level
// RULE12 - pending register unmasked, cleared on acknowledge
// RULE13 - read request selects pending or in-service
// RULE14 - read selection retained, pending after init
// RULE15 - port select high reads mask directly
// RULE16 - poll overrides register read request
// RULE17 - edge mode: rising transition only
// RULE18 - level mode: high level is request
// RULE19 - early drop gives default level seven
// RULE20 - cascade nested mode allows same level
// RULE21 - buffer enable matches data bus drive
// RULE22 - fixed priority after init, zero highest
// RULE23 - non-specific end clears highest in-service
// RULE24 - selective mask spares masked in-service bits
`include "intc_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module interrupt_priority_modes
  import intc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic port_select_line,
  input wire logic [7:0] data_in,
  input wire logic interrupt_ack_pulse_n,
  input wire logic [7:0] request_input,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic int_request,
  output logic buffer_enable_out_n
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  cpu_bus_s bus_meta_reg;
  cpu_bus_s bus_reg;
  cpu_bus_s bus_prev_reg;
  logic [7:0] req_meta_reg;
  logic [7:0] req_sync_reg;
  logic [7:0] req_prev_reg;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      bus_meta_reg <= '1;
      bus_reg <= '1;
      bus_prev_reg <= '1;
    end
    else
    begin
      bus_meta_reg <= {cs_n, rd_n, wr_n, port_select_line, interrupt_ack_pulse_n, data_in};
      bus_reg <= bus_meta_reg;
      bus_prev_reg <= bus_reg;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      req_meta_reg <= 8'h00;
      req_sync_reg <= 8'h00;
    end
    else
    begin
      req_meta_reg <= request_input;
      req_sync_reg <= req_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus events

  logic wr_done;
  logic rd_start;
  logic rd_active;
  logic ack_fall;
  logic ack_rise;
  logic [7:0] wdata;
  logic wr_init_one;
  logic wr_status;
  logic wr_priority;
  logic wr_port_one;
  logic wr_mask;
  priority_command_word_s pcw;
  status_command_word_s scw;
  init_word_four_s four_reg;
  init_state_e init_state_reg;

  // data and select are taken from the cycle before write goes inactive
  assign wr_done = !bus_prev_reg.wr_n && bus_reg.wr_n && !bus_prev_reg.cs_n;
  assign wdata = bus_prev_reg.data;
  assign rd_active = !bus_reg.rd_n && !bus_reg.cs_n;
  assign rd_start = rd_active && bus_prev_reg.rd_n;
  assign ack_fall = bus_prev_reg.ack_n && !bus_reg.ack_n;
  assign ack_rise = !bus_prev_reg.ack_n && bus_reg.ack_n;
  assign pcw = wdata;
  assign scw = wdata;

  assign wr_port_one = wr_done && bus_prev_reg.port_select_line;
  assign wr_init_one = wr_done && !bus_prev_reg.port_select_line && wdata[`SEL_INIT_ONE_BIT];
  assign wr_status = wr_done && !bus_prev_reg.port_select_line
    && !wdata[`SEL_INIT_ONE_BIT] && wdata[`SEL_STATUS_BIT];
  assign wr_priority = wr_done && !bus_prev_reg.port_select_line
    && !wdata[`SEL_INIT_ONE_BIT] && !wdata[`SEL_STATUS_BIT];
  assign wr_mask = wr_port_one && (init_state_reg == INIT_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // initialization sequence and operating modes

  logic level_trig_reg;
  logic single_reg;
  logic need_four_reg;
  logic [4:0] vector_base_reg;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      init_state_reg <= INIT_IDLE;
      level_trig_reg <= 1'b0;
      single_reg <= 1'b1;
      need_four_reg <= 1'b0;
      vector_base_reg <= `VECTOR_BASE_RESET;
      four_reg <= `INIT_FOUR_RESET;
    end
    else if (wr_init_one)
    begin
      init_state_reg <= INIT_VECTOR;
      level_trig_reg <= wdata[`INIT1_TRIGGER_BIT];
      single_reg <= wdata[`INIT1_SINGLE_BIT];
      need_four_reg <= wdata[`INIT1_NEED_FOUR_BIT];
      four_reg <= `INIT_FOUR_RESET;
    end
    else if (wr_port_one)
    begin
      case (init_state_reg)
        INIT_IDLE:
          init_state_reg <= INIT_IDLE;
        INIT_VECTOR:
        begin
          vector_base_reg <= wdata[`VECTOR_BASE_MSB:`VECTOR_BASE_LSB];
          if (!single_reg)
            init_state_reg <= INIT_CASCADE;
          else if (need_four_reg)
            init_state_reg <= INIT_FOUR;
          else
            init_state_reg <= INIT_IDLE;
        end
        // cascade word is accepted and not used by this block
        INIT_CASCADE:
          init_state_reg <= need_four_reg ? INIT_FOUR : INIT_IDLE;
        INIT_FOUR:
        begin
          four_reg <= wdata;
          init_state_reg <= INIT_IDLE;
        end
        default:
          init_state_reg <= INIT_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mask, mode and read selection

  logic [7:0] channel_mask_reg;
  logic smm_reg;
  logic read_isr_reg;
  logic poll_reg;
  logic rotate_auto_reg;

  always_ff @(posedge mclk)
  begin
    if (rst || wr_init_one)
      channel_mask_reg <= `MASK_RESET;
    else if (wr_mask)
      channel_mask_reg <= wdata;
  end

  always_ff @(posedge mclk)
  begin
    if (rst || wr_init_one)
    begin
      smm_reg <= 1'b0;
      read_isr_reg <= 1'b0; // RULE14
    end
    else if (wr_status)
    begin
      if (scw.selective_mask_write_enable)
        smm_reg <= scw.selective_mask_mode; // RULE8
      if (scw.status_read_request && !scw.poll)
        read_isr_reg <= scw.status_select; // RULE13 RULE16
    end
  end

  // poll stays armed from its write up to the read that consumes it
  always_ff @(posedge mclk)
  begin
    if (rst || wr_init_one)
      poll_reg <= 1'b0;
    else if (wr_status && scw.poll)
      poll_reg <= 1'b1; // RULE16
    else if (rd_start)
      poll_reg <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (rst || wr_init_one)
      rotate_auto_reg <= 1'b0;
    else if (wr_priority && !pcw.level_sel && !pcw.end_of_service_cmd)
      rotate_auto_reg <= pcw.rotate; // RULE3
  end

  ////////////////////////////////////////////////////////////////////////////
  // priority resolution

  logic [7:0] pending_request_reg;
  logic [7:0] in_service_reg;
  logic [2:0] bottom_reg;
  logic req_valid;
  logic [2:0] req_level;
  logic eos_valid;
  logic [2:0] eos_level;
  logic int_ok;
  logic grant_valid;

  priority_resolver u_resolver (
    .requests(pending_request_reg & ~channel_mask_reg), // RULE6
    .blocking(smm_reg ? 8'h00 : in_service_reg), // RULE7
    .eos_candidates(smm_reg ? (in_service_reg & ~channel_mask_reg) : in_service_reg), // RULE24
    .bottom(bottom_reg),
    .nested(four_reg.cascade_nested_mode),
    .req_valid(req_valid),
    .req_level(req_level),
    .eos_valid(eos_valid),
    .eos_level(eos_level),
    .int_ok(int_ok)
  );

  assign grant_valid = req_valid && int_ok;

  ////////////////////////////////////////////////////////////////////////////
  // acknowledge sequence, poll acknowledge and end of service

  logic ack_phase_reg;
  logic [2:0] served_level_reg;
  logic take;
  logic [2:0] take_level;
  logic auto_end;
  logic nonspec_end;
  logic spec_end;

  // a poll read is taken exactly as a first acknowledge pulse
  assign take = (ack_fall && !ack_phase_reg) || (rd_start && poll_reg); // RULE9
  // a request gone before the acknowledge leaves the default level
  assign take_level = grant_valid ? req_level : `DEFAULT_LEVEL; // RULE19
  assign auto_end = ack_rise && ack_phase_reg && four_reg.auto_service_end_mode;
  assign nonspec_end = (wr_priority && pcw.end_of_service_cmd && !pcw.level_sel) || auto_end;
  assign spec_end = wr_priority && pcw.end_of_service_cmd && pcw.level_sel;

  always_ff @(posedge mclk)
  begin
    if (rst || wr_init_one)
    begin
      ack_phase_reg <= 1'b0;
      served_level_reg <= `DEFAULT_LEVEL;
    end
    else
    begin
      if (take)
        served_level_reg <= take_level;
      if (ack_rise)
        ack_phase_reg <= !ack_phase_reg;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst || wr_init_one)
      in_service_reg <= `IN_SERVICE_RESET;
    else
    begin
      for (int i = 0; i < 8; i++)
      begin
        if (take && grant_valid && (req_level == 3'(i)))
          in_service_reg[i] <= 1'b1; // RULE19
        else if (spec_end && (pcw.level_select_field == 3'(i)))
          in_service_reg[i] <= 1'b0; // RULE5
        else if (nonspec_end && eos_valid && (eos_level == 3'(i)))
          in_service_reg[i] <= 1'b0; // RULE2 RULE23
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst || wr_init_one)
      bottom_reg <= `BOTTOM_RESET; // RULE22
    else if (wr_priority && pcw.rotate && pcw.level_sel)
      bottom_reg <= pcw.level_select_field; // RULE4 RULE5
    else if (wr_priority && pcw.rotate && pcw.end_of_service_cmd && eos_valid)
      bottom_reg <= eos_level; // RULE2
    else if (auto_end && rotate_auto_reg)
      bottom_reg <= served_level_reg; // RULE1
  end

  ////////////////////////////////////////////////////////////////////////////
  // request capture

  logic [7:0] req_captured;

  // edge mode: a latch set by a rising input and emptied while the input is low
  assign req_captured = level_trig_reg ? req_sync_reg // RULE18
    : ((pending_request_reg | (req_sync_reg & ~req_prev_reg)) & req_sync_reg); // RULE17

  always_ff @(posedge mclk)
  begin
    if (rst || wr_init_one)
    begin
      pending_request_reg <= `PENDING_RESET;
      req_prev_reg <= 8'hff;
    end
    else if (poll_reg && !take)
      pending_request_reg <= pending_request_reg; // RULE10
    else
    begin
      req_prev_reg <= req_sync_reg;
      for (int i = 0; i < 8; i++)
      begin
        if (take && grant_valid && (req_level == 3'(i)))
          pending_request_reg[i] <= 1'b0; // RULE12
        else
          pending_request_reg[i] <= req_captured[i];
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst || wr_init_one)
      int_request <= 1'b0;
    else if (!poll_reg)
      int_request <= grant_valid; // RULE10
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data and bus drive

  logic oe_reg;

  always_ff @(posedge mclk)
  begin
    if (rst)
      data_out <= 8'h00;
    else if (rd_start && poll_reg)
      data_out <= {grant_valid, 4'h0, take_level}; // RULE11
    else if (rd_start && bus_reg.port_select_line)
      data_out <= channel_mask_reg; // RULE15
    else if (rd_start)
      data_out <= read_isr_reg ? in_service_reg : pending_request_reg; // RULE13 RULE14
    else if (ack_fall && ack_phase_reg)
      data_out <= {vector_base_reg, served_level_reg};
  end

  // the vector goes out during the second acknowledge pulse only
  always_ff @(posedge mclk)
  begin
    if (rst)
      oe_reg <= 1'b0;
    else
      oe_reg <= rd_active || (!bus_reg.ack_n && ack_phase_reg);
  end

  assign data_oe = oe_reg;
  assign buffer_enable_out_n = !(four_reg.buffered && oe_reg); // RULE21

endmodule

`default_nettype wire

//--- testbench/ipm_checker.sv
// port assertions for the interrupt priority and mode logic
`timescale 1ns/1ps
`default_nettype none

module ipm_checker
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic interrupt_ack_pulse_n,
  input wire logic [7:0] request_input,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic int_request,
  input wire logic buffer_enable_out_n
);
  logic ack_prev_reg;
  logic ack_odd_reg;
  logic [3:0] idle_age_reg;

  // pins are raw here while the design syncs them, so windows allow the lag
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ack_prev_reg <= 1'b1;
      ack_odd_reg <= 1'b0;
    end
    else
    begin
      ack_prev_reg <= interrupt_ack_pulse_n;
      ack_odd_reg <= ack_odd_reg ^ (interrupt_ack_pulse_n & ~ack_prev_reg);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst || (!rd_n && !cs_n) || !interrupt_ack_pulse_n)
      idle_age_reg <= 4'h0;
    else if (idle_age_reg != 4'hf)
      idle_age_reg <= idle_age_reg + 4'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_reset_quiet: assert property ($fell(rst) |-> !data_oe && !int_request && data_out == 8'h00)
    else $error("outputs not idle after reset");
  a_buffer_off_idle: assert property (!data_oe |-> buffer_enable_out_n)
    else $error("buffer enable active while bus not driven");
  a_buffer_tracks_oe: assert property ($changed(buffer_enable_out_n) |-> $changed(data_oe))
    else $error("buffer enable moved without the bus drive");
  a_oe_after_strobe: assert property (data_oe |-> idle_age_reg <= 4'h5)
    else $error("bus driven without a read or acknowledge");
  a_read_drives_bus: assert property ((!rd_n && !cs_n) [*5] |-> data_oe)
    else $error("selected read did not drive the bus");
  a_data_holds: assert property (data_oe && $past(data_oe) |-> $stable(data_out))
    else $error("read data changed while driven");
  a_first_ack_quiet: assert property ($fell(interrupt_ack_pulse_n) && !ack_odd_reg |-> (!data_oe) [*8])
    else $error("first acknowledge drove the bus");
  a_no_request_idle: assert property ((request_input == 8'h00) [*6] |-> !int_request)
    else $error("interrupt raised with no request");

  c_int_raised: cover property ($rose(int_request));
  c_buffered_drive: cover property (data_oe && !buffer_enable_out_n);
  c_ack_vector: cover property (data_oe && ack_odd_reg);
endmodule

`default_nettype wire

//--- testbench/cpu_model.sv
// processor side: command writes, status reads and acknowledge pulses
`timescale 1ns/1ps
`default_nettype none

module cpu_model
(
  input wire logic mclk,
  input wire logic [7:0] data_out,
  input wire logic buffer_enable_out_n,
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic port_select_line,
  output logic [7:0] data_in,
  output logic interrupt_ack_pulse_n
);
  initial
  begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    port_select_line = 1'b0;
    data_in = 8'h00;
    interrupt_ack_pulse_n = 1'b1;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // strobe phases of four or more cycles cover the design's input sync lag
  task automatic wr(input logic ps, input logic [7:0] d);
    cyc(1);
    cs_n = 1'b0;
    port_select_line = ps;
    data_in = d;
    cyc(4);
    wr_n = 1'b0;
    cyc(4);
    wr_n = 1'b1;
    cyc(4);
    cs_n = 1'b1;
    // released bus must not keep showing the written byte
    data_in = ~d;
    cyc(2);
  endtask

  task automatic rd(input logic ps, output logic [7:0] v);
    cyc(1);
    cs_n = 1'b0;
    port_select_line = ps;
    cyc(4);
    rd_n = 1'b0;
    cyc(6);
    v = data_out;
    rd_n = 1'b1;
    cyc(4);
    cs_n = 1'b1;
    cyc(4);
  endtask

  // always two pulses, otherwise the design's pulse count misaligns
  task automatic ack(output logic [7:0] v, output logic b);
    cyc(1);
    interrupt_ack_pulse_n = 1'b0;
    cyc(5);
    interrupt_ack_pulse_n = 1'b1;
    cyc(5);
    interrupt_ack_pulse_n = 1'b0;
    cyc(6);
    v = data_out;
    b = buffer_enable_out_n;
    interrupt_ack_pulse_n = 1'b1;
    cyc(6);
  endtask
endmodule

`default_nettype wire

//--- testbench/tb_top.sv
// testbench for the interrupt priority and mode logic
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic mclk;
  logic rst;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic port_select_line;
  logic [7:0] data_in;
  logic interrupt_ack_pulse_n;
  logic [7:0] request_input;
  logic [7:0] data_out;
  logic data_oe;
  logic int_request;
  logic buffer_enable_out_n;
  int errors = 0;
  int tests_run = 0;

  interrupt_priority_modes interrupt_priority_modes_inst (.mclk(mclk), .rst(rst), .cs_n(cs_n),
    .rd_n(rd_n), .wr_n(wr_n), .port_select_line(port_select_line), .data_in(data_in),
    .interrupt_ack_pulse_n(interrupt_ack_pulse_n), .request_input(request_input),
    .data_out(data_out), .data_oe(data_oe), .int_request(int_request),
    .buffer_enable_out_n(buffer_enable_out_n));
  cpu_model cpu_model_inst (.mclk(mclk), .data_out(data_out),
    .buffer_enable_out_n(buffer_enable_out_n), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .port_select_line(port_select_line), .data_in(data_in),
    .interrupt_ack_pulse_n(interrupt_ack_pulse_n));

  ////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic cmp(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cw(input logic ps, input logic [7:0] d);
    cpu_model_inst.wr(ps, d);
  endtask

  task automatic rdc(input logic ps, input logic [7:0] exp);
    logic [7:0] v;
    cpu_model_inst.rd(ps, v);
    cmp(v, exp);
  endtask

  task automatic ackc(input logic [7:0] exp);
    logic [7:0] v;
    logic b;
    cpu_model_inst.ack(v, b);
    cmp(v, exp);
  endtask

  // eight cycles lets a new level pass the sync and detect stages
  task automatic rq(input logic [7:0] r);
    request_input = r;
    cyc(8);
  endtask

  task automatic give_verdict;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rdc(1'b1, 8'h00);
    rdc(1'b0, 8'h00);
    cw(1'b1, 8'ha5);
    rdc(1'b1, 8'ha5);
    cw(1'b1, 8'h00);
  endtask

  task automatic t_fixed;
    rq(8'h90);
    rdc(1'b0, 8'h90);
    ackc(8'h04);
    rdc(1'b0, 8'h80);
    cw(1'b0, 8'h0b);
    rdc(1'b0, 8'h10);
    rdc(1'b0, 8'h10);
    cw(1'b0, 8'h20);
    rdc(1'b0, 8'h00);
    ackc(8'h07);
    cw(1'b0, 8'h20);
    rq(8'h00);
  endtask

  task automatic t_rotate;
    rq(8'h10);
    ackc(8'h04);
    cw(1'b0, 8'ha0);
    rdc(1'b0, 8'h00);
    rq(8'h38);
    ackc(8'h05);
    cw(1'b0, 8'ha0);
    rq(8'h00);
    rq(8'h50);
    ackc(8'h06);
    cw(1'b0, 8'h20);
    rq(8'h00);
  endtask

  task automatic t_setprio;
    cw(1'b0, 8'hc2);
    rq(8'h12);
    ackc(8'h04);
    cw(1'b0, 8'he4);
    rdc(1'b0, 8'h00);
    rq(8'h00);
    rq(8'h28);
    ackc(8'h05);
    cw(1'b0, 8'h20);
    rq(8'h00);
    cw(1'b0, 8'hc7);
  endtask

  task automatic t_mask;
    cw(1'b1, 8'h01);
    rq(8'h03);
    ackc(8'h01);
    cw(1'b0, 8'h68);
    cw(1'b1, 8'h03);
    rq(8'h23);
    ackc(8'h05);
    cw(1'b0, 8'h20);
    rdc(1'b0, 8'h02);
    cw(1'b0, 8'h48);
    cw(1'b1, 8'h00);
    rq(8'h00);
    cw(1'b0, 8'h20);
  endtask

  task automatic t_poll;
    rq(8'h04);
    cw(1'b0, 8'h0e);
    rdc(1'b0, 8'h82);
    cw(1'b0, 8'h0b);
    rdc(1'b0, 8'h04);
    cw(1'b0, 8'h20);
    rq(8'h00);
    cw(1'b0, 8'h0c);
    rq(8'h04);
    rdc(1'b0, 8'h07);
    cw(1'b0, 8'h0b);
  endtask

  // the request drops before the acknowledge on purpose
  task automatic t_default;
    rq(8'h04);
    rq(8'h00);
    ackc(8'h07);
    rdc(1'b0, 8'h00);
  endtask

  task automatic t_level;
    logic [7:0] v;
    logic b;
    cw(1'b0, 8'h1b);
    cw(1'b1, 8'h40);
    cw(1'b1, 8'h0d);
    rq(8'h01);
    rdc(1'b0, 8'h01);
    cpu_model_inst.ack(v, b);
    cmp(v, 8'h40);
    cmp({7'h00, b}, 8'h00);
    cw(1'b0, 8'h20);
    cyc(4);
    cmp({7'h00, int_request}, 8'h01);
    rq(8'h00);
    cmp({7'h00, int_request}, 8'h00);
  endtask

  // auto end with rotation on and off, then nested mode passing the in-service level
  task automatic t_auto;
    cw(1'b0, 8'h13);
    cw(1'b1, 8'h00);
    cw(1'b1, 8'h02);
    cw(1'b0, 8'h80);
    rq(8'h04);
    ackc(8'h02);
    rq(8'h0e);
    ackc(8'h03);
    cw(1'b0, 8'h00);
    ackc(8'h01);
    rq(8'h00);
    rq(8'h05);
    ackc(8'h00);
    rq(8'h00);
    cw(1'b0, 8'h13);
    cw(1'b1, 8'h00);
    cw(1'b1, 8'h10);
    rq(8'h04);
    ackc(8'h02);
    rq(8'h00);
    rq(8'h04);
    cmp({7'h00, int_request}, 8'h01);
    cw(1'b0, 8'h20);
    rq(8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial
  begin
    #200000;
    errors++;
    give_verdict();
  end

  initial
  begin
    rst = 1'b1;
    request_input = 8'h00;
    cyc(2);
    rst = 1'b0;
    cyc(4);
    t_regs();
    t_fixed();
    t_rotate();
    t_setprio();
    t_mask();
    t_poll();
    t_default();
    t_level();
    t_auto();
    give_verdict();
  end
endmodule

bind interrupt_priority_modes ipm_checker ipm_checker_inst (.mclk(mclk), .rst(rst),
  .cs_n(cs_n), .rd_n(rd_n), .interrupt_ack_pulse_n(interrupt_ack_pulse_n),
  .request_input(request_input), .data_out(data_out), .data_oe(data_oe),
  .int_request(int_request), .buffer_enable_out_n(buffer_enable_out_n));

`default_nettype wire
